// file: mprs_pkg.sv
// Purpose: shared constants and types for the power/reset request link
// Assumes: 10 MHz system clock at both ends
// Notes:   times in ms, cycle counts derived from them
package mprs_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned PWR_ON_MIN_MS   = 25;
  localparam int unsigned RESET_MIN_MS    = 20;
  localparam int unsigned POWER_UP_MIN_MS = 2000;
  localparam int unsigned PWR_ON_MIN_CYC  = PWR_ON_MIN_MS * CYC_PER_MS;
  localparam int unsigned RESET_MIN_CYC   = RESET_MIN_MS * CYC_PER_MS;
  localparam int unsigned POWER_UP_CYC    = POWER_UP_MIN_MS * CYC_PER_MS;
  localparam int unsigned CNT_W           = 25;
  localparam int unsigned CLR_CYC         = 16;

  typedef enum logic [3:0] {
    DEV_OFF   = 4'b0001,
    DEV_ON    = 4'b0010,
    DEV_CLEAR = 4'b0100,
    DEV_DOWN  = 4'b1000
  } mprs_dev_state_type;

  typedef enum logic [3:0] {
    HST_IDLE  = 4'b0001,
    HST_PULSE = 4'b0010,
    HST_WAIT  = 4'b0100,
    HST_UP    = 4'b1000
  } mprs_hst_state_type;

  function automatic logic [CNT_W-1:0] mprs_sat_inc(input logic [CNT_W-1:0] v);
    return (&v) ? v : v + 25'h000_0001;
  endfunction : mprs_sat_inc
endpackage : mprs_pkg

// file: mprs_link_if.sv
// Purpose: open-drain request pins and alive rail between host and module
// Assumes: pull-ups of the module make released pins read high
// Notes:   resolved levels computed from the enables
`timescale 1ns/100ps
interface mprs_link_if;
  logic power_on_request_n_o;
  logic power_on_request_n_oe;
  logic reset_request_n_o;
  logic reset_request_n_oe;
  logic module_alive_rail;
  logic power_on_request_n;
  logic reset_request_n;

  // pull-up wins when nobody pulls low
  assign power_on_request_n = power_on_request_n_oe ? power_on_request_n_o : 1'b1;
  assign reset_request_n    = reset_request_n_oe ? reset_request_n_o : 1'b1;

  modport host (output power_on_request_n_o, power_on_request_n_oe,
                output reset_request_n_o, reset_request_n_oe,
                input  module_alive_rail);
  modport device (input  power_on_request_n, reset_request_n,
                  output module_alive_rail);
endinterface : mprs_link_if

// file: mprs_device.sv
// Purpose: module-side power-on, reset and shutdown sequencer
// Assumes: request pins arrive asynchronously, released pins read high
// Notes:   clear phase wipes cpu state before the next power-on
`timescale 1ns/100ps
// What host and module do on the link
// - low power-on request switches module on
// - power-on request must stay low 25 ms
// - host waits 2000 ms after power-on edge
// - power-on pin idles high through pull-up
// - host drives power-on pin open-drain only
// - alive rail low off, high on
// - power-on pin never switches off; shutdown command
// - reset pulse low at least 20 ms
// - valid reset with power-on low restarts
// - valid reset with power-on high powers off
// - reset clears cpu registers and memory
// - host waits 2000 ms after reset edge
// - host drives reset pin open-drain only
module mprs_device
  import mprs_pkg::*;
(
  input  wire logic  clk_sys_i,
  input  wire logic  reset_n_i,
  mprs_link_if.device link,
  input  wire logic  shutdown_command_i,
  output logic       cpu_run_o,
  output logic       cpu_clear_o
);

  typedef struct packed {
    logic [2:0]         pwr_sync;
    logic [2:0]         rst_sync;
    logic               pwr_lvl;
    logic               rst_lvl;
    logic [CNT_W-1:0]   pwr_cnt;
    logic [CNT_W-1:0]   rst_cnt;
    logic               rst_valid;
    logic               restart;
    logic [4:0]         clr_cnt;
    mprs_dev_state_type state;
    logic               alive;
    logic               run;
    logic               clear;
  } mprs_dev_regs_type;

  mprs_dev_regs_type regs_ff;
  mprs_dev_regs_type nxt_regs;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_regs = regs_ff;
    nxt_regs.pwr_sync = {regs_ff.pwr_sync[1:0], link.power_on_request_n};
    nxt_regs.rst_sync = {regs_ff.rst_sync[1:0], link.reset_request_n};
    if (regs_ff.pwr_sync[2] == regs_ff.pwr_sync[1]) begin
      nxt_regs.pwr_lvl = regs_ff.pwr_sync[2];
    end
    if (regs_ff.rst_sync[2] == regs_ff.rst_sync[1]) begin
      nxt_regs.rst_lvl = regs_ff.rst_sync[2];
    end

    // low-duration counters
    nxt_regs.pwr_cnt = regs_ff.pwr_lvl ? '0 : mprs_sat_inc(regs_ff.pwr_cnt);
    nxt_regs.rst_cnt = regs_ff.rst_lvl ? '0 : mprs_sat_inc(regs_ff.rst_cnt);
    nxt_regs.rst_valid = 1'b0;
    // reset acts on release of a long enough pulse
    if (regs_ff.rst_lvl == 1'b0 && nxt_regs.rst_lvl == 1'b1 &&
        regs_ff.rst_cnt >= CNT_W'(RESET_MIN_CYC - 1)) begin
      nxt_regs.rst_valid = 1'b1;
    end

    case (regs_ff.state)
      DEV_OFF: begin
        if (!regs_ff.pwr_lvl && regs_ff.pwr_cnt >= CNT_W'(PWR_ON_MIN_CYC - 1)) begin
          nxt_regs.state = DEV_ON;
        end
      end
      DEV_ON: begin
        if (regs_ff.rst_valid) begin
          nxt_regs.restart = ~regs_ff.pwr_lvl;
          nxt_regs.clr_cnt = '0;
          nxt_regs.state   = DEV_CLEAR;
        end else if (shutdown_command_i) begin
          nxt_regs.state = DEV_DOWN;
        end
      end
      DEV_CLEAR: begin
        nxt_regs.clr_cnt = regs_ff.clr_cnt + 5'h01;
        if (regs_ff.clr_cnt == 5'(CLR_CYC - 1)) begin
          nxt_regs.state = regs_ff.restart ? DEV_ON : DEV_OFF;
        end
      end
      DEV_DOWN: begin
        // power-on must be released before a new switch-on counts
        if (regs_ff.pwr_lvl) begin
          nxt_regs.state = DEV_OFF;
        end
      end
      default: begin
        nxt_regs.state = DEV_OFF;
      end
    endcase

    nxt_regs.alive = (nxt_regs.state == DEV_ON) || (nxt_regs.state == DEV_CLEAR && nxt_regs.restart);
    nxt_regs.run   = (nxt_regs.state == DEV_ON);
    nxt_regs.clear = (nxt_regs.state == DEV_CLEAR);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      regs_ff <= '{pwr_sync: 3'h7, rst_sync: 3'h7, pwr_lvl: 1'b1, rst_lvl: 1'b1,
                   pwr_cnt: '0, rst_cnt: '0, rst_valid: 1'b0, restart: 1'b0,
                   clr_cnt: '0, state: DEV_OFF, alive: 1'b0, run: 1'b0,
                   clear: 1'b0};
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  assign link.module_alive_rail = regs_ff.alive;
  assign cpu_run_o              = regs_ff.run;
  assign cpu_clear_o            = regs_ff.clear;

endmodule : mprs_device

// file: mprs_host.sv
// Purpose: host-side driver of the open-drain power and reset requests
// Assumes: same 10 MHz clock as the module logic
// Notes:   up_o rises only after the minimum power-up period
`timescale 1ns/100ps
module mprs_host
  import mprs_pkg::*;
(
  input  wire logic  clk_sys_i,
  input  wire logic  reset_n_i,
  mprs_link_if.host  link,
  input  wire logic  power_on_i,
  input  wire logic  reset_i,
  input  wire logic  hold_power_on_i,
  output logic       busy_o,
  output logic       up_o,
  output logic       alive_o
);

  typedef struct packed {
    mprs_hst_state_type state;
    logic               is_reset;
    logic [CNT_W-1:0]   cnt;
    logic [2:0]         alive_sync;
    logic               alive_lvl;
    logic               pwr_drive;
    logic               rst_drive;
    logic               busy;
    logic               up;
  } mprs_hst_regs_type;

  mprs_hst_regs_type regs_ff;
  mprs_hst_regs_type nxt_regs;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_regs = regs_ff;
    nxt_regs.alive_sync = {regs_ff.alive_sync[1:0], link.module_alive_rail};
    if (regs_ff.alive_sync[2] == regs_ff.alive_sync[1]) begin
      nxt_regs.alive_lvl = regs_ff.alive_sync[2];
    end
    nxt_regs.cnt = mprs_sat_inc(regs_ff.cnt);
    case (regs_ff.state)
      HST_IDLE: begin
        if (reset_i) begin
          nxt_regs.state    = HST_PULSE;
          nxt_regs.is_reset = 1'b1;
          nxt_regs.cnt      = '0;
        end else if (power_on_i) begin
          nxt_regs.state    = HST_PULSE;
          nxt_regs.is_reset = 1'b0;
          nxt_regs.cnt      = '0;
        end
      end
      HST_PULSE: begin
        // pin is low from the edge that enters pulse, so count the full minimum
        if (regs_ff.is_reset ? regs_ff.cnt >= CNT_W'(RESET_MIN_CYC)
                             : regs_ff.cnt >= CNT_W'(PWR_ON_MIN_CYC)) begin
          nxt_regs.state = HST_WAIT;
        end
      end
      HST_WAIT: begin
        if (regs_ff.cnt >= CNT_W'(POWER_UP_CYC)) begin
          nxt_regs.state = HST_UP;
        end
      end
      HST_UP: begin
        if (reset_i) begin
          nxt_regs.state    = HST_PULSE;
          nxt_regs.is_reset = 1'b1;
          nxt_regs.cnt      = '0;
        end else if (!regs_ff.alive_lvl) begin
          nxt_regs.state = HST_IDLE;
        end
      end
      default: begin
        nxt_regs.state = HST_IDLE;
      end
    endcase
    nxt_regs.rst_drive = (nxt_regs.state == HST_PULSE) && nxt_regs.is_reset;
    nxt_regs.pwr_drive = ((nxt_regs.state == HST_PULSE) && !nxt_regs.is_reset)
                         || hold_power_on_i;
    nxt_regs.busy = (nxt_regs.state == HST_PULSE) || (nxt_regs.state == HST_WAIT);
    nxt_regs.up   = (nxt_regs.state == HST_UP);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      regs_ff <= '{state: HST_IDLE, is_reset: 1'b0, cnt: '0, alive_sync: 3'h0,
                   alive_lvl: 1'b0, pwr_drive: 1'b0, rst_drive: 1'b0,
                   busy: 1'b0, up: 1'b0};
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // open-drain: only ever pull low
  assign link.power_on_request_n_o  = 1'b0;
  assign link.power_on_request_n_oe = regs_ff.pwr_drive;
  assign link.reset_request_n_o     = 1'b0;
  assign link.reset_request_n_oe    = regs_ff.rst_drive;
  assign busy_o                     = regs_ff.busy;
  assign up_o                       = regs_ff.up;
  assign alive_o                    = regs_ff.alive_lvl;

endmodule : mprs_host

// file: mprs_monitor.sv
// Purpose: wire-level checks beside the host/module request link
// Assumes: one clock, device reset gates all checks
// Notes:   run counters keep the length of the last low pulse
`timescale 1ns/100ps
module mprs_monitor
  import mprs_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic power_on_request_n_o,
  input wire logic power_on_request_n_oe,
  input wire logic reset_request_n_o,
  input wire logic reset_request_n_oe,
  input wire logic module_alive_rail,
  input wire logic power_on_request_n,
  input wire logic reset_request_n
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic [CNT_W-1:0] pwr_run_ff;
  logic [CNT_W-1:0] rst_run_ff;
  logic             pwr_lo_ff;
  logic             rst_lo_ff;
  // ----------------------------------------
  // last low pulse length of each pin
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pwr_run_ff <= '0;
      rst_run_ff <= '0;
      pwr_lo_ff  <= 1'b0;
      rst_lo_ff  <= 1'b0;
    end else begin
      pwr_lo_ff <= !power_on_request_n;
      rst_lo_ff <= !reset_request_n;
      if (!power_on_request_n) pwr_run_ff <= pwr_lo_ff ? pwr_run_ff + 1'b1 : 25'h000_0001;
      if (!reset_request_n) rst_run_ff <= rst_lo_ff ? rst_run_ff + 1'b1 : 25'h000_0001;
    end
  end
  AST_OD_POWER: assert property (power_on_request_n_oe |-> !power_on_request_n_o)
    else $error("power pin driven high");
  AST_OD_RESET: assert property (reset_request_n_oe |-> !reset_request_n_o)
    else $error("reset pin driven high");
  AST_ON_NEEDS_LOW: assert property ($rose(module_alive_rail) |-> !$past(power_on_request_n, 8))
    else $error("module on without low power request");
  AST_MIN_LOW: assert property ($rose(module_alive_rail) |-> pwr_run_ff >= CNT_W'(PWR_ON_MIN_CYC))
    else $error("module on after too short request");
  AST_NO_OFF: assert property ($rose(power_on_request_n) && module_alive_rail |=> module_alive_rail [*8])
    else $error("power pin release switched module off");
  AST_RESTART: assert property ($rose(reset_request_n) && !power_on_request_n && module_alive_rail
    && rst_run_ff >= CNT_W'(RESET_MIN_CYC) |-> module_alive_rail [*8])
    else $error("restart dropped alive rail");
  AST_POWER_OFF: assert property ($rose(reset_request_n) && power_on_request_n && module_alive_rail
    && rst_run_ff >= CNT_W'(RESET_MIN_CYC) |-> ##[1:8] !module_alive_rail)
    else $error("reset with power high left module on");
  AST_RESET_HOLD: assert property ($rose(reset_request_n_oe) |=> reset_request_n_oe [*8])
    else $error("reset pulse too short");
endmodule : mprs_monitor

// file: mprs_test.sv
// Purpose: host and module joined, power/reset/shutdown sequences
// Assumes: full-length counts, host reset used to leave its wait
// Notes:   alive rail changes compared against a queue of notes
`timescale 1ns/100ps
module mprs_test;
  import mprs_pkg::*;
  logic clk_sys_i, rst_dev_n, rst_hst_n, power_on, reset_req, hold_on, shutdown;
  logic cpu_run, cpu_clear, busy, prev_alive;
  logic exp_q[$];
  int   n_mismatch, total_checks;
  mprs_link_if link();
  mprs_device i_mprs_device (.clk_sys_i(clk_sys_i), .reset_n_i(rst_dev_n), .link(link),
    .shutdown_command_i(shutdown), .cpu_run_o(cpu_run), .cpu_clear_o(cpu_clear));
  mprs_host i_mprs_host (.clk_sys_i(clk_sys_i), .reset_n_i(rst_hst_n), .link(link),
    .power_on_i(power_on), .reset_i(reset_req), .hold_power_on_i(hold_on), .busy_o(busy),
    .up_o(), .alive_o());
  mprs_monitor i_mprs_monitor (.clk_sys_i(clk_sys_i), .reset_n_i(rst_dev_n),
    .power_on_request_n_o(link.power_on_request_n_o),
    .power_on_request_n_oe(link.power_on_request_n_oe),
    .reset_request_n_o(link.reset_request_n_o), .reset_request_n_oe(link.reset_request_n_oe),
    .module_alive_rail(link.module_alive_rail), .power_on_request_n(link.power_on_request_n),
    .reset_request_n(link.reset_request_n));
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task check(input logic seen, input logic expd, input string msg);
    total_checks++;
    if (seen !== expd) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : check
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  function automatic logic pick(input int w);
    return (w == 0) ? cpu_run : cpu_clear;
  endfunction : pick
  task automatic wait_on(input int w, input logic v, input int lim);
    int i;
    i = 0;
    while (pick(w) !== v && i < lim) begin
      @(negedge clk_sys_i);
      i++;
    end
    if (i >= lim) begin
      n_mismatch++;
      $display("MISMATCH at %0t: wait timed out", $time);
      end_sim();
    end
  endtask : wait_on
  task pulse(input int w);
    @(negedge clk_sys_i);
    if (w == 0) power_on = 1'b1; else if (w == 1) reset_req = 1'b1; else shutdown = 1'b1;
    @(negedge clk_sys_i);
    power_on  = 1'b0;
    reset_req = 1'b0;
    shutdown  = 1'b0;
  endtask : pulse
  task host_restart;
    @(negedge clk_sys_i);
    rst_hst_n = 1'b0;
    @(negedge clk_sys_i);
    rst_hst_n = 1'b1;
    repeat ($urandom_range(1, 16)) @(negedge clk_sys_i);
  endtask : host_restart
  // ----------------------------------------
  // alive rail watcher
  // ----------------------------------------
  always @(negedge clk_sys_i) begin
    if (rst_dev_n && link.module_alive_rail !== prev_alive) begin
      if (exp_q.size() == 0) check(link.module_alive_rail, prev_alive, "alive moved unasked");
      else check(link.module_alive_rail, exp_q.pop_front(), "alive level");
    end
    prev_alive <= link.module_alive_rail;
  end
  initial begin
    {rst_dev_n, rst_hst_n, power_on, reset_req, hold_on, shutdown, prev_alive} = '0;
    n_mismatch   = 0;
    total_checks = 0;
    void'($urandom(32'h8caffe89));
    repeat (6) @(negedge clk_sys_i);
    rst_dev_n = 1'b1;
    rst_hst_n = 1'b1;
    check(link.module_alive_rail, 1'b0, "alive after reset");
    check(link.power_on_request_n, 1'b1, "power pin idle");
    repeat ($urandom_range(1, 16)) @(negedge clk_sys_i);
    exp_q.push_back(1'b1);
    pulse(0);
    check(busy, 1'b1, "host busy");
    check(link.power_on_request_n, 1'b0, "power pin low");
    wait_on(0, 1'b1, 250100);
    host_restart();
    hold_on = 1'b1;
    pulse(1);
    check(link.reset_request_n, 1'b0, "reset pin low");
    wait_on(1, 1'b1, 200100);
    check(link.module_alive_rail, 1'b1, "alive on restart");
    wait_on(0, 1'b1, 40);
    check(busy, 1'b1, "host still in power-up wait");
    host_restart();
    hold_on = 1'b0;
    exp_q.push_back(1'b0);
    pulse(1);
    wait_on(0, 1'b0, 200100);
    repeat (8) @(negedge clk_sys_i);
    check(link.module_alive_rail, 1'b0, "powered off");
    host_restart();
    exp_q.push_back(1'b1);
    pulse(0);
    wait_on(0, 1'b1, 250100);
    exp_q.push_back(1'b0);
    pulse(2);
    wait_on(0, 1'b0, 100);
    repeat (8) @(negedge clk_sys_i);
    check(exp_q.size() == 0, 1'b1, "alive change missing");
    end_sim();
  end
endmodule : mprs_test
